// file: pcm_map.svh
/*
 * Register map, field masks, reset values and timing constants
 * of the pll configuration and clock interrupt mask block.
 * Assumes a 32-bit register port with byte addresses.
 */
`ifndef PCM_MAP_SVH
`define PCM_MAP_SVH

// register byte addresses
`define PCM_ADDR_PLLA_CFG   32'h400E_0428
`define PCM_ADDR_IRQ_EN     32'h400E_0460
`define PCM_ADDR_IRQ_DIS    32'h400E_0464
`define PCM_ADDR_STATUS     32'h400E_0468
`define PCM_ADDR_IRQ_MASK   32'h400E_046C
`define PCM_ADDR_WP_MODE    32'h400E_04E4

// reset values
`define PCM_PLLA_RST        32'h2000_3F00
`define PCM_ZERO32          32'h0000_0000
`define PCM_WP_BIT          0

// implemented clock event bits of status and mask
`define PCM_IRQ_VALID       32'h0007_070F

// pll field codes
`define PCM_DIV_OFF         8'h00
`define PCM_DIV_BYPASS      8'h01
`define PCM_MULT_OFF        11'h000

// clock rates for the slow clock enable
`define PCM_CLK_HZ          25000000
`define PCM_SLCK_HZ         32768

`endif

// file: pcm_pkg.sv
/*
 * Types shared by the pll configuration block.
 * Assumes pcm_map.svh supplies the numeric constants.
 */
package pcm_pkg;

    // layout of the pll configuration word
    typedef struct packed {
        logic [1:0]  rsv_hi;
        logic        one;
        logic [1:0]  rsv_a;
        logic [10:0] mult;
        logic [1:0]  rsv_b;
        logic [5:0]  lock_count;
        logic [7:0]  prediv;
    } pcm_pll_cfg_t;

    // layout of status and mask words
    typedef struct packed {
        logic [12:0] rsv_hi;
        logic        clock_fail_event;
        logic        rc_osc_stable;
        logic        main_osc_select_done;
        logic [4:0]  rsv_m;
        logic [2:0]  prog_clock_ready;
        logic [3:0]  rsv_l;
        logic        master_clock_ready;
        logic        pll_b_locked;
        logic        pll_a_locked;
        logic        xtal_osc_stable;
    } pcm_irq_t;

endpackage

// file: pcm_prediv.sv
/*
 * Front-end divider of the first pll: turns the input clock enable
 * into a divided enable pulse.
 * Assumes tick_in is a one-cycle enable on clk.
 */
`timescale 1ns/1ns
`include "pcm_map.svh"

module pcm_prediv
(
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       tick_in,
    input  wire logic [7:0] prediv,
    output logic            div_out
);

    logic [7:0] cnt;

    ////////////////////////////////////////////////////////////////////
    // divide counter, restarted when divider is off or bypassed
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            cnt <= 8'h00;
        else if (prediv == `PCM_DIV_OFF || prediv == `PCM_DIV_BYPASS)
            cnt <= 8'h00;
        else if (tick_in)
        begin
            if (cnt >= prediv - 8'h01)
                cnt <= 8'h00;
            else
                cnt <= cnt + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // divider output
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            div_out <= 1'h0;
        else if (prediv == `PCM_DIV_OFF)
            div_out <= 1'h0;
        else if (prediv == `PCM_DIV_BYPASS)
            div_out <= tick_in;
        else
            div_out <= tick_in && (cnt >= prediv - 8'h01);
    end

endmodule

// file: pcm_top.sv
/*
 * Configuration logic of the first pll and the clock interrupt mask:
 * pll configuration register with write protection, slow clock lock
 * counter, sticky clock status, read-only mask and interrupt line.
 * Assumes a single 25 MHz clock, a register port with read data one
 * cycle after the strobe, and asynchronous clock event levels.
 */
`timescale 1ns/1ns
`include "pcm_map.svh"

// Overview of operation
// - divider field zero holds divider output low, pll disabled
// - divider field one passes input clock undivided, pll enabled if multiplier non-zero
// - divider field 2 to 255 divides input clock by that value
// - after config write, wait lock count slow cycles then set lock
// - multiplier field zero disables pll regardless of divider
// - multiplier 7 to 62 gives output frequency input times field+1
// - config writes ignored while write protection is enabled
// - mask register is read-only, one means interrupt enabled
// - mask bits: crystal 0, pll a lock 1, pll b lock 2, mck 3
// - mask bits: prog clocks 8-10, osc select 16, rc 17, fail 18
module pcm_top
    import pcm_pkg::*;
#(
    parameter int CLK_HZ   = `PCM_CLK_HZ,
    parameter int SLCK_HZ  = `PCM_SLCK_HZ,
    parameter int SLCK_DIV = CLK_HZ / SLCK_HZ
)
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [31:0] addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    input  wire logic        pll_in_tick,
    input  wire logic [31:0] clk_events,
    output logic             irq,
    output logic             pll_a_div_tick,
    output logic             pll_a_enable,
    output logic      [11:0] pll_a_factor,
    output logic             pll_a_locked
);

    localparam int SW = $clog2(SLCK_DIV + 1);

    pcm_pll_cfg_t  pll_a_config;
    pcm_irq_t      clock_irq_mask;
    pcm_irq_t      clock_status_reg;
    pcm_irq_t      next_status;
    logic          write_protect_enable;
    logic [31:0]   evt_meta;
    logic [31:0]   evt_sync;
    logic [31:0]   evt_prev;
    logic [31:0]   evt_rise;
    logic [SW-1:0] slck_cnt;
    logic          slck_tick;
    logic [5:0]    lock_cnt;
    logic          lock_run;
    logic          lock_set;
    logic          cfg_wr;
    logic          next_lock;
    logic [31:0]   next_rdata;

    ////////////////////////////////////////////////////////////////////
    // pll is running only with both divider and multiplier non-zero
    function automatic logic pcm_pll_on(input pcm_pll_cfg_t c);
        pcm_pll_on = (c.prediv != `PCM_DIV_OFF) &&
                     (c.mult != `PCM_MULT_OFF);
    endfunction

    // register write hit at one byte address
    function automatic logic pcm_hit(input logic [31:0] a,
                                     input logic [31:0] ref_a);
        pcm_hit = (a == ref_a);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // two-flop synchroniser for the asynchronous clock event levels
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            evt_meta <= `PCM_ZERO32;
            evt_sync <= `PCM_ZERO32;
        end
        else
        begin
            evt_meta <= clk_events;
            evt_sync <= evt_meta;
        end
    end

    // previous synchronised level for rising edge detection
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            evt_prev <= `PCM_ZERO32;
        else
            evt_prev <= evt_sync;
    end

    // rising edges of implemented events; pll a lock is internal
    always_comb
    begin
        evt_rise = evt_sync & ~evt_prev & `PCM_IRQ_VALID;
        evt_rise[1] = lock_set;
    end

    ////////////////////////////////////////////////////////////////////
    // slow clock enable, one pulse per slow clock period
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            slck_cnt  <= '0;
            slck_tick <= 1'h0;
        end
        else if (slck_cnt >= SW'(SLCK_DIV - 1))
        begin
            slck_cnt  <= '0;
            slck_tick <= 1'h1;
        end
        else
        begin
            slck_cnt  <= slck_cnt + SW'(1);
            slck_tick <= 1'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // accepted configuration write, dropped under write protection
    assign cfg_wr = wr && pcm_hit(addr, `PCM_ADDR_PLLA_CFG)
                    && !write_protect_enable;

    // pll configuration register
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            pll_a_config <= pcm_pll_cfg_t'(`PCM_PLLA_RST);
        else if (cfg_wr)
            pll_a_config <= pcm_pll_cfg_t'(wdata);
    end

    // write protection mode bit
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            write_protect_enable <= 1'h0;
        else if (wr && pcm_hit(addr, `PCM_ADDR_WP_MODE))
            write_protect_enable <= wdata[`PCM_WP_BIT];
    end

    ////////////////////////////////////////////////////////////////////
    // interrupt mask: set by enable writes, cleared by disable writes
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            clock_irq_mask <= pcm_irq_t'(`PCM_ZERO32);
        else if (wr && pcm_hit(addr, `PCM_ADDR_IRQ_EN))
            clock_irq_mask <= pcm_irq_t'((clock_irq_mask | wdata)
                              & `PCM_IRQ_VALID);
        else if (wr && pcm_hit(addr, `PCM_ADDR_IRQ_DIS))
            clock_irq_mask <= pcm_irq_t'(clock_irq_mask & ~wdata);
    end

    ////////////////////////////////////////////////////////////////////
    // lock counter: reloaded on every accepted write, counts slow ticks
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            lock_cnt <= 6'h00;
            lock_run <= 1'h0;
        end
        else if (cfg_wr)
        begin
            lock_cnt <= wdata[13:8];
            lock_run <= pcm_pll_on(pcm_pll_cfg_t'(wdata));
        end
        else if (!pcm_pll_on(pll_a_config))
            lock_run <= 1'h0;
        else if (lock_run && slck_tick)
        begin
            if (lock_cnt <= 6'h01)
                lock_run <= 1'h0;
            else
                lock_cnt <= lock_cnt - 6'h01;
        end
    end

    // lock flag rises when the counted wait ends
    always_comb
    begin
        lock_set  = lock_run && slck_tick && (lock_cnt <= 6'h01)
                    && !cfg_wr && pcm_pll_on(pll_a_config);
        next_lock = pll_a_locked;
        if (cfg_wr || !pcm_pll_on(pll_a_config))
            next_lock = 1'h0;
        else if (lock_set)
            next_lock = 1'h1;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            pll_a_locked <= 1'h0;
        else
            pll_a_locked <= next_lock;
    end

    ////////////////////////////////////////////////////////////////////
    // front-end divider of the pll input clock enable
    pcm_prediv i_pcm_prediv
    (
        .clk     (clk),
        .nrst    (nrst),
        .tick_in (pll_in_tick),
        .prediv  (pll_a_config.prediv),
        .div_out (pll_a_div_tick)
    );

    // pll enable and multiplication factor
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pll_a_enable <= 1'h0;
            pll_a_factor <= 12'h000;
        end
        else
        begin
            pll_a_enable <= pcm_pll_on(pll_a_config);
            if (pcm_pll_on(pll_a_config))
                pll_a_factor <= {1'h0, pll_a_config.mult}
                                + 12'h001;
            else
                pll_a_factor <= 12'h000;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sticky status: event set wins over write-one-to-clear
    always_comb
    begin
        next_status = clock_status_reg;
        if (wr && pcm_hit(addr, `PCM_ADDR_STATUS))
            next_status = pcm_irq_t'(clock_status_reg & ~wdata);
        next_status = pcm_irq_t'((next_status | evt_rise)
                      & `PCM_IRQ_VALID);
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            clock_status_reg <= pcm_irq_t'(`PCM_ZERO32);
        else
            clock_status_reg <= next_status;
    end

    // level interrupt from unmasked status bits
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            irq <= 1'h0;
        else
            irq <= |(next_status & clock_irq_mask);
    end

    ////////////////////////////////////////////////////////////////////
    // read multiplexer, unmapped addresses read zero
    always_comb
    begin
        next_rdata = `PCM_ZERO32;
        if (rd)
        begin
            case (addr)
                `PCM_ADDR_PLLA_CFG:
                    next_rdata = pll_a_config;
                `PCM_ADDR_IRQ_MASK:
                    next_rdata = clock_irq_mask;
                `PCM_ADDR_STATUS:
                    next_rdata = clock_status_reg;
                `PCM_ADDR_WP_MODE:
                    next_rdata[`PCM_WP_BIT] = write_protect_enable;
                default:
                    next_rdata = `PCM_ZERO32;
            endcase
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rdata <= `PCM_ZERO32;
        else
            rdata <= next_rdata;
    end

endmodule

// file: pcm_top_chk.sv
/* pcm_top_chk: port-level assertions for pcm_top.
   assumes a bind into pcm_top with its SLCK_DIV handed on. */
`timescale 1ns/1ns
`include "pcm_map.svh"
module pcm_top_chk
#(
    parameter int SLCK_DIV = 4
)
(
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    input wire logic        pll_in_tick,
    input wire logic        irq,
    input wire logic        pll_a_div_tick,
    input wire logic        pll_a_enable,
    input wire logic [11:0] pll_a_factor,
    input wire logic        pll_a_locked
);
    logic        wp_q;
    logic [31:0] mask_q;
    logic [13:0] cfg_q;
    logic [15:0] since;
    logic        cfg_w;

    ////////////////////////////////////////////////////////////////////
    // accepted config write: right address, protection off
    assign cfg_w = wr && addr == `PCM_ADDR_PLLA_CFG && !wp_q;

    // shadow of protection, mask and low config fields
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wp_q   <= 1'b0;
            mask_q <= 32'h0000_0000;
            cfg_q  <= 14'h3F00;
        end
        else if (wr)
        begin
            if (addr == `PCM_ADDR_WP_MODE)
                wp_q <= wdata[0];
            if (addr == `PCM_ADDR_IRQ_EN)
                mask_q <= mask_q | (wdata & `PCM_IRQ_VALID);
            if (addr == `PCM_ADDR_IRQ_DIS)
                mask_q <= mask_q & ~wdata;
            if (cfg_w)
                cfg_q <= wdata[13:0];
        end
    end

    // cycles since the last accepted config write, saturating
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            since <= 16'h0000;
        else if (cfg_w)
            since <= 16'h0000;
        else if (since != 16'hFFFF)
            since <= since + 16'h0001;
    end

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence cfg_wr_s;
        cfg_w;
    endsequence
    sequence lock_rise_s;
        $rose(pll_a_locked);
    endsequence

    chk_rd_idle: assert property (
        !$past(rd) |-> rdata == 32'h0000_0000)
        else $error("read data not zero outside a read");
    chk_off_factor: assert property (
        !pll_a_enable |-> pll_a_factor == 12'h000)
        else $error("factor not zero while pll disabled");
    chk_off_unlock: assert property (
        !pll_a_enable |-> !pll_a_locked)
        else $error("lock set while pll disabled");
    chk_wr_unlock: assert property (
        cfg_wr_s |=> !pll_a_locked)
        else $error("lock not cleared by config write");
    chk_lock_early: assert property (
        lock_rise_s |-> since + 2 * SLCK_DIV > cfg_q[13:8] * SLCK_DIV)
        else $error("lock set before its slow count");
    chk_lock_late: assert property (
        lock_rise_s |-> since <= cfg_q[13:8] * SLCK_DIV + SLCK_DIV + 4)
        else $error("lock set after its slow count");
    chk_mask_quiet: assert property (
        mask_q == 32'h0000_0000 && $past(mask_q) == 32'h0000_0000 |-> !irq)
        else $error("interrupt with every event masked");
    chk_mask_read: assert property (
        rd && addr == `PCM_ADDR_IRQ_MASK |=> rdata == $past(mask_q))
        else $error("mask read value wrong");
    chk_div_stuck: assert property (
        cfg_q[7:0] == 8'h00 && $past(cfg_q[7:0]) == 8'h00
        |-> !pll_a_div_tick)
        else $error("divider output moved with divider zero");
endmodule

bind pcm_top pcm_top_chk #(.SLCK_DIV(SLCK_DIV)) i_pcm_top_chk
(
    .clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .pll_in_tick, .irq,
    .pll_a_div_tick, .pll_a_enable, .pll_a_factor, .pll_a_locked
);

// file: pcm_top_tb.sv
/* pcm_top_tb: self-checking bench for pcm_top.
   assumes the register port of pcm_top and a short slow clock divide. */
`timescale 1ns/1ns
`include "pcm_map.svh"
module pcm_top_tb;
    localparam int SD = 4;
    logic        clk;
    logic        nrst;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        pll_in_tick;
    logic [31:0] clk_events;
    logic        irq;
    logic        pll_a_div_tick;
    logic        pll_a_enable;
    logic [11:0] pll_a_factor;
    logic        pll_a_locked;
    int          n_mismatch;
    int          n_tests;

    pcm_top #(.SLCK_DIV(SD)) i_pcm_top
    (
        .clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .pll_in_tick,
        .clk_events, .irq, .pll_a_div_tick, .pll_a_enable, .pll_a_factor,
        .pll_a_locked
    );

    ////////////////////////////////////////////////////////////////////
    // shared compare, bus cycles and waits
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, e);
    endtask
    task automatic neg(input int n);
        repeat (n) @(negedge clk);
    endtask
    // one input tick, then the divider output in the following cycle
    task automatic tick(output logic seen);
        @(posedge clk);
        pll_in_tick <= 1'b1;
        @(posedge clk);
        pll_in_tick <= 1'b0;
        @(negedge clk);
        seen = pll_a_div_tick;
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd_chk(`PCM_ADDR_PLLA_CFG, 32'h2000_3F00);
        rd_chk(`PCM_ADDR_IRQ_MASK, 32'h0000_0000);
        rd_chk(32'h400E_0500, 32'h0000_0000);
        chk({31'h0, pll_a_enable}, 32'h0000_0000);
        $display("t_reset done");
    endtask
    task automatic t_bypass_lock;
        int   k;
        logic s;
        wr_reg(`PCM_ADDR_PLLA_CFG, 32'h2007_0201);
        for (k = 0; k < 100 && !pll_a_locked; k++)
            @(negedge clk);
        chk({31'h0, k >= SD && k <= 2 * SD + 4}, 32'h0000_0001);
        chk({31'h0, pll_a_enable}, 32'h0000_0001);
        chk({20'h0, pll_a_factor}, 32'h0000_0008);
        tick(s);
        chk({31'h0, s}, 32'h0000_0001);
        neg(1);
        chk({31'h0, pll_a_div_tick}, 32'h0000_0000);
        rd_chk(`PCM_ADDR_STATUS, 32'h0000_0002);
        wr_reg(`PCM_ADDR_PLLA_CFG, 32'h2007_0201);
        neg(1);
        chk({31'h0, pll_a_locked}, 32'h0000_0000);
        $display("t_bypass_lock done");
    endtask
    task automatic t_divide;
        int   n;
        logic s;
        n = 0;
        wr_reg(`PCM_ADDR_PLLA_CFG, 32'h203E_0103);
        repeat (6)
        begin
            tick(s);
            n += s;
        end
        chk(n, 32'h0000_0002);
        chk({20'h0, pll_a_factor}, 32'h0000_003F);
        $display("t_divide done");
    endtask
    task automatic t_off;
        logic s;
        wr_reg(`PCM_ADDR_PLLA_CFG, 32'h2000_0103);
        neg(3);
        chk({19'h0, pll_a_enable, pll_a_factor}, 32'h0000_0000);
        chk({31'h0, pll_a_locked}, 32'h0000_0000);
        wr_reg(`PCM_ADDR_PLLA_CFG, 32'h2007_0100);
        neg(3);
        tick(s);
        chk({30'h0, pll_a_enable, s}, 32'h0000_0000);
        $display("t_off done");
    endtask
    task automatic t_protect;
        wr_reg(`PCM_ADDR_WP_MODE, 32'h0000_0001);
        wr_reg(`PCM_ADDR_PLLA_CFG, 32'h2007_0201);
        rd_chk(`PCM_ADDR_PLLA_CFG, 32'h2007_0100);
        wr_reg(`PCM_ADDR_WP_MODE, 32'h0000_0000);
        $display("t_protect done");
    endtask
    task automatic t_irq;
        wr_reg(`PCM_ADDR_STATUS, 32'hFFFF_FFFF);
        wr_reg(`PCM_ADDR_IRQ_EN, 32'hFFFF_FFFF);
        rd_chk(`PCM_ADDR_IRQ_MASK, 32'h0007_070F);
        wr_reg(`PCM_ADDR_IRQ_MASK, 32'h0000_0000);
        wr_reg(`PCM_ADDR_IRQ_DIS, 32'hFFFF_FFFE);
        rd_chk(`PCM_ADDR_IRQ_MASK, 32'h0000_0001);
        @(posedge clk);
        clk_events <= 32'h0000_0001;
        neg(6);
        chk({31'h0, irq}, 32'h0000_0001);
        rd_chk(`PCM_ADDR_STATUS, 32'h0000_0001);
        wr_reg(`PCM_ADDR_IRQ_DIS, 32'h0000_0001);
        neg(2);
        chk({31'h0, irq}, 32'h0000_0000);
        @(posedge clk);
        clk_events <= 32'h0000_0000;
        $display("t_irq done");
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    // 40 ns clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // hang guard, well past the hundred or so cycles of the tests
    initial
    begin
        #100000;
        n_mismatch++;
        print_verdict();
    end

    // reset, then the scenarios in order
    initial
    begin
        n_mismatch  = 0;
        n_tests     = 0;
        nrst        = 1'b0;
        addr        = 32'h0000_0000;
        wdata       = 32'h0000_0000;
        wr          = 1'b0;
        rd          = 1'b0;
        pll_in_tick = 1'b0;
        clk_events  = 32'h0000_0000;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_bypass_lock();
        t_divide();
        t_off();
        t_protect();
        t_irq();
        print_verdict();
    end
endmodule
